/* rtl/swlt_pkg.sv */
// package: constants, register map and state types for the switch output link timeout block
// Function
// - zero recovery time holds outputs indefinitely
// - sender accepts 20 to 57600 s, default 20
// - receiver accepts 60 to 57600 s, default 60
// - timeout forces outputs to open state
// - keep searching for link while lost
// - timeout turns indicator off, clears arming and delay runs
// - follow mode mirrors sender input state
// - toggle mode inverts once per close-open
// - delayed close waits 1 to 5000 s
// - closed contact reports active, open reports normal
package swlt_pkg;

	// channel count and clock timing
	localparam int CH_NUM = 4;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SEC_NS = 1000000000;
	localparam int TICK_CYC = SEC_NS / CLK_PERIOD_NS;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RECOV = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_INT_STAT = 8'h10;
	localparam logic [7:0] OFS_INT_MASK = 8'h14;
	localparam logic [7:0] OFS_CH_IN = 8'h18;

	// recovery time limits and defaults, seconds
	localparam logic [15:0] RECOV_OFF = 16'h0000;
	localparam logic [15:0] RECOV_MAX = 16'he100;
	localparam logic [15:0] RECOV_TX_MIN = 16'h0014;
	localparam logic [15:0] RECOV_TX_DEF = 16'h0014;
	localparam logic [15:0] RECOV_RX_MIN = 16'h003c;
	localparam logic [15:0] RECOV_RX_DEF = 16'h003c;
	localparam logic [15:0] LOSS_SAT = 16'hffff;

	// delayed close limits and default, seconds
	localparam logic [12:0] DLY_MIN = 13'h0001;
	localparam logic [12:0] DLY_MAX = 13'h1388;
	localparam logic [12:0] DLY_DEF = 13'h0001;

	// interrupt bit positions
	localparam int INT_W = 4;
	localparam int INT_LOST = 0;
	localparam int INT_TOUT = 1;
	localparam int INT_BACK = 2;
	localparam int INT_CFG = 3;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// output modes
	typedef enum logic [1:0] {
		MODE_FOLLOW = 2'b00,
		MODE_TOGGLE = 2'b01,
		MODE_DELAY = 2'b10
	} swlt_mode_type;

	// whole state of the top module
	typedef struct packed {
		logic init;
		logic role;
		logic awready;
		logic wready;
		logic arready;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		swlt_mode_type mode;
		logic [15:0] recov;
		logic [12:0] dly;
		logic ind;
		logic search;
		logic timed_out;
		logic link_prev;
		logic [15:0] loss_cnt;
		logic [CH_NUM-1:0] ch_in;
		logic [CH_NUM-1:0] ch_out;
		logic [CH_NUM-1:0] armed;
		logic [CH_NUM-1:0] dly_run;
		logic [CH_NUM-1:0][12:0] dly_cnt;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic irq;
	} swlt_state_type;

endpackage

/* rtl/swlt_sec_tick.sv */
// module: divider making a one-cycle seconds tick
`timescale 1ns/10ps
module swlt_sec_tick #(
	parameter int TICK_CYC = 10000000
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// tick out
	output logic o_tick
);
	localparam int CW = $clog2(TICK_CYC);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);

	logic [CW-1:0] cnt_q;

	// free running count, pulse on wrap
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
		end else begin
			o_tick <= (cnt_q == LAST);
			if (cnt_q == LAST) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + CW'(1);
			end
		end
	end
endmodule

/* rtl/swlt_top.sv */
// module: receiver output control with link-loss timeout and axi4-lite registers
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module swlt_top #(
	parameter int TICK_CYC = swlt_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// role strap, high for the sending-end unit
	input wire logic I_ROLE_SENDER,
	// link status and received frames
	input wire logic I_LINK_UP,
	input wire logic I_FRAME_VALID,
	input wire logic [swlt_pkg::CH_NUM-1:0] I_FRAME_CH_STATE,
	// axi4-lite write address
	input wire logic I_AWVALID,
	input wire logic [7:0] I_AWADDR,
	output logic O_AWREADY,
	// axi4-lite write data
	input wire logic I_WVALID,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_WREADY,
	// axi4-lite write response
	output logic O_BVALID,
	output logic [1:0] O_BRESP,
	input wire logic I_BREADY,
	// axi4-lite read address
	input wire logic I_ARVALID,
	input wire logic [7:0] I_ARADDR,
	output logic O_ARREADY,
	// axi4-lite read data
	output logic O_RVALID,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire logic I_RREADY,
	// channel outputs, high is closed
	output logic [swlt_pkg::CH_NUM-1:0] O_CH_OUT,
	// indicators and interrupt
	output logic O_LINK_INDICATOR,
	output logic O_LINK_SEARCH,
	output logic O_IRQ
);
	swlt_pkg::swlt_state_type s;
	swlt_pkg::swlt_state_type n;
	logic tick;
	logic [31:0] wval;
	logic [31:0] rword;
	logic rmiss;
	localparam int INT_W_L = swlt_pkg::INT_W;
	logic [15:0] rec_min;
	logic [INT_W_L-1:0] ev;
	logic [INT_W_L-1:0] w1c;

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// seconds tick
	swlt_sec_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RST),
		.o_tick(tick)
	);

	// read word selection
	always_comb begin
		rword = 32'h0000_0000;
		rmiss = 1'b0;
		case (I_ARADDR)
			swlt_pkg::OFS_CTRL: rword = {30'h0, s.mode};
			swlt_pkg::OFS_RECOV: rword = {16'h0000, s.recov};
			swlt_pkg::OFS_DELAY: rword = {19'h0, s.dly};
			swlt_pkg::OFS_STATUS: begin
				rword = {s.loss_cnt, 8'h00, s.ch_out, s.search, s.role, s.timed_out, s.ind};
			end
			swlt_pkg::OFS_INT_STAT: rword = {28'h0, s.int_stat};
			swlt_pkg::OFS_INT_MASK: rword = {28'h0, s.int_mask};
			swlt_pkg::OFS_CH_IN: rword = {28'h0, s.ch_in};
			default: rmiss = 1'b1;
		endcase
	end

	// next state of the whole block
	always_comb begin
		n = s;
		ev = '0;
		w1c = '0;
		wval = 32'h0000_0000;
		rec_min = s.role ? swlt_pkg::RECOV_TX_MIN : swlt_pkg::RECOV_RX_MIN;

		// first cycle after reset: capture strap, load power-up defaults
		if (!s.init) begin
			n.init = 1'b1;
			n.role = I_ROLE_SENDER;
			n.recov = I_ROLE_SENDER ? swlt_pkg::RECOV_TX_DEF : swlt_pkg::RECOV_RX_DEF;
			n.dly = swlt_pkg::DLY_DEF;
			n.awready = 1'b1;
			n.wready = 1'b1;
			n.arready = 1'b1;
		end

		// write address and data taken in either order
		if (I_AWVALID && s.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = I_AWADDR;
			n.awready = 1'b0;
		end
		if (I_WVALID && s.wready) begin
			n.w_got = 1'b1;
			n.wdata = I_WDATA;
			n.wstrb = I_WSTRB;
			n.wready = 1'b0;
		end

		// register write once both halves are held
		if (s.aw_got && s.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = swlt_pkg::RESP_OKAY;
			case (s.awaddr)
				swlt_pkg::OFS_CTRL: begin
					wval = merge_be({30'h0, s.mode}, s.wdata, s.wstrb);
					if (wval[1:0] == 2'b11) begin
						ev[swlt_pkg::INT_CFG] = 1'b1;
					end else if (wval[1:0] != s.mode) begin
						n.mode = swlt_pkg::swlt_mode_type'(wval[1:0]);
						n.armed = '0;
						n.dly_run = '0;
					end
				end
				swlt_pkg::OFS_RECOV: begin
					wval = merge_be({16'h0000, s.recov}, s.wdata, s.wstrb);
					// zero disables recovery, else role range only
					if (wval[31:16] == 16'h0000 && (wval[15:0] == swlt_pkg::RECOV_OFF ||
						(wval[15:0] >= rec_min && wval[15:0] <= swlt_pkg::RECOV_MAX))) begin
						n.recov = wval[15:0];
					end else begin
						ev[swlt_pkg::INT_CFG] = 1'b1;
					end
				end
				swlt_pkg::OFS_DELAY: begin
					wval = merge_be({19'h0, s.dly}, s.wdata, s.wstrb);
					if (wval[31:13] == 19'h0 && wval[12:0] >= swlt_pkg::DLY_MIN &&
						wval[12:0] <= swlt_pkg::DLY_MAX) begin
						n.dly = wval[12:0];
					end else begin
						ev[swlt_pkg::INT_CFG] = 1'b1;
					end
				end
				swlt_pkg::OFS_INT_STAT: begin
					wval = merge_be(32'h0000_0000, s.wdata, s.wstrb);
					w1c = wval[INT_W_L-1:0];
				end
				swlt_pkg::OFS_INT_MASK: begin
					wval = merge_be({28'h0, s.int_mask}, s.wdata, s.wstrb);
					n.int_mask = wval[INT_W_L-1:0];
				end
				swlt_pkg::OFS_STATUS, swlt_pkg::OFS_CH_IN: ; // read only, ignored
				default: n.bresp = swlt_pkg::RESP_SLVERR;
			endcase
		end
		if (s.bvalid && I_BREADY) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end

		// read: answer one cycle after the address is taken
		if (I_ARVALID && s.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rword;
			n.rresp = rmiss ? swlt_pkg::RESP_SLVERR : swlt_pkg::RESP_OKAY;
		end
		if (s.rvalid && I_RREADY) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end

		// link watch: search while down, count whole seconds of loss
		n.link_prev = I_LINK_UP;
		n.search = !I_LINK_UP;
		if (s.link_prev && !I_LINK_UP) begin
			ev[swlt_pkg::INT_LOST] = 1'b1;
		end
		if (!s.link_prev && I_LINK_UP && s.init) begin
			ev[swlt_pkg::INT_BACK] = 1'b1;
		end
		if (tick && !I_LINK_UP && s.loss_cnt != swlt_pkg::LOSS_SAT) begin
			n.loss_cnt = s.loss_cnt + 16'h0001;
		end

		// per-channel output behaviour
		for (int c = 0; c < swlt_pkg::CH_NUM; c++) begin
			case (s.mode)
				swlt_pkg::MODE_FOLLOW: begin
					if (I_FRAME_VALID) begin
						n.ch_out[c] = I_FRAME_CH_STATE[c];
					end
				end
				swlt_pkg::MODE_TOGGLE: begin
					if (I_FRAME_VALID) begin
						if (I_FRAME_CH_STATE[c]) begin
							n.armed[c] = 1'b1;
						end else if (s.armed[c]) begin
							n.armed[c] = 1'b0;
							n.ch_out[c] = !s.ch_out[c];
						end
					end
				end
				swlt_pkg::MODE_DELAY: begin
					if (I_FRAME_VALID && I_FRAME_CH_STATE[c]) begin
						n.armed[c] = 1'b1;
						n.dly_run[c] = 1'b0;
						n.ch_out[c] = 1'b0;
					end else if (I_FRAME_VALID && s.armed[c]) begin
						n.armed[c] = 1'b0;
						n.dly_run[c] = 1'b1;
						n.dly_cnt[c] = 13'h0000;
					end else if (s.dly_run[c] && tick) begin
						// close once the delay in seconds has passed
						if (s.dly_cnt[c] + 13'h0001 >= s.dly) begin
							n.dly_run[c] = 1'b0;
							n.ch_out[c] = 1'b1;
						end else begin
							n.dly_cnt[c] = s.dly_cnt[c] + 13'h0001;
						end
					end
				end
				default: ;
			endcase
		end

		// a valid frame restarts the loss count and lights the indicator
		if (I_FRAME_VALID) begin
			n.ch_in = I_FRAME_CH_STATE;
			n.loss_cnt = 16'h0000;
			n.timed_out = 1'b0;
			n.ind = 1'b1;
		end else if (s.recov != swlt_pkg::RECOV_OFF && s.loss_cnt > s.recov &&
			!s.timed_out) begin
			// loss outlasted recovery time: open outputs, indicator off
			n.timed_out = 1'b1;
			n.ind = 1'b0;
			n.ch_out = '0;
			n.armed = '0;
			n.dly_run = '0;
			ev[swlt_pkg::INT_TOUT] = 1'b1;
		end

		// sticky status, set wins over clear
		n.int_stat = (s.int_stat & ~w1c) | ev;
		n.irq = |(n.int_stat & n.int_mask);
	end

	// state register
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// outputs straight from state flops
	assign O_AWREADY = s.awready;
	assign O_WREADY = s.wready;
	assign O_BVALID = s.bvalid;
	assign O_BRESP = s.bresp;
	assign O_ARREADY = s.arready;
	assign O_RVALID = s.rvalid;
	assign O_RDATA = s.rdata;
	assign O_RRESP = s.rresp;
	assign O_CH_OUT = s.ch_out;
	assign O_LINK_INDICATOR = s.ind;
	assign O_LINK_SEARCH = s.search;
	assign O_IRQ = s.irq;

	// checks on the block's own behaviour
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RST);

	sequence frame_seq;
		I_FRAME_VALID;
	endsequence

	sequence expiry_seq;
		!I_FRAME_VALID && s.recov != swlt_pkg::RECOV_OFF && s.loss_cnt > s.recov &&
			!s.timed_out && s.init;
	endsequence

	recov_off_hold_a: assert property (
		s.recov == swlt_pkg::RECOV_OFF && !s.timed_out |=> !s.timed_out)
		else $error("timeout taken with recovery disabled");

	recov_range_a: assert property (
		s.init |-> s.recov == swlt_pkg::RECOV_OFF ||
			(s.recov >= rec_min && s.recov <= swlt_pkg::RECOV_MAX))
		else $error("recovery time outside accepted range");

	recov_default_a: assert property (
		!s.init ##1 s.init |-> s.recov == (s.role ? swlt_pkg::RECOV_TX_DEF :
			swlt_pkg::RECOV_RX_DEF))
		else $error("wrong power-up recovery time");

	timeout_open_a: assert property (
		expiry_seq |=> s.timed_out && O_CH_OUT == '0)
		else $error("outputs not opened at timeout");

	search_level_a: assert property (
		!I_LINK_UP |=> O_LINK_SEARCH)
		else $error("search stopped while link lost");

	indicator_off_a: assert property (
		$rose(s.timed_out) |-> !O_LINK_INDICATOR ##1 (!O_LINK_INDICATOR || $past(I_FRAME_VALID)))
		else $error("indicator lit after timeout");

	follow_mirror_a: assert property (
		I_FRAME_VALID && s.mode == swlt_pkg::MODE_FOLLOW |=> O_CH_OUT == $past(I_FRAME_CH_STATE))
		else $error("follow output does not mirror input");

	toggle_flip_a: assert property (
		I_FRAME_VALID && s.mode == swlt_pkg::MODE_TOGGLE && s.armed[0] && !I_FRAME_CH_STATE[0]
		|=> O_CH_OUT[0] != $past(O_CH_OUT[0]))
		else $error("toggle output did not invert");

	delay_range_a: assert property (
		s.init |-> s.dly >= swlt_pkg::DLY_MIN && s.dly <= swlt_pkg::DLY_MAX)
		else $error("delay outside accepted range");

	ch_report_a: assert property (
		frame_seq |=> s.ch_in == $past(I_FRAME_CH_STATE))
		else $error("channel state not reported");

	loss_clear_a: assert property (
		frame_seq |=> s.loss_cnt == 16'h0000 ##1 s.loss_cnt <= 16'h0001)
		else $error("loss count not cleared by frame");

	irq_level_a: assert property (
		|(s.int_stat & s.int_mask) |-> O_IRQ)
		else $error("interrupt not raised for pending status");
endmodule

/* dv/swlt_peer_model.sv */
// paired sending unit model: radio link state and channel frames
`timescale 1ns/10ps
module swlt_peer_model (
	// clock
	input wire logic i_clk,
	// link and frames
	output logic o_link_up,
	output logic o_frame_valid,
	output logic [swlt_pkg::CH_NUM-1:0] o_frame_ch_state
);
	// idle link up, no frame
	initial begin
		o_link_up = 1'b1;
		o_frame_valid = 1'b0;
		o_frame_ch_state = '0;
	end
	// one frame; payload inverted once released so stale data never looks valid
	task automatic send(input logic [swlt_pkg::CH_NUM-1:0] st);
		@(posedge i_clk);
		o_frame_valid <= 1'b1;
		o_frame_ch_state <= st;
		@(posedge i_clk);
		o_frame_valid <= 1'b0;
		o_frame_ch_state <= ~st;
	endtask
	// radio link up or down
	task automatic link(input logic up);
		@(posedge i_clk);
		o_link_up <= up;
	endtask
endmodule

/* dv/swlt_top_tb.sv */
// testbench for the switch output link timeout block
`timescale 1ns/10ps
module swlt_top_tb;
	localparam int TCK = 10;
	logic clk, rst, role, awv, wv, bready, arv, rready, link_up, fv;
	logic awrdy, wrdy, bvalid, arrdy, rvalid, ind, srch, irq;
	logic [7:0] aa, ara;
	logic [31:0] wd, rdat, rdata;
	logic [1:0] resp, bresp, rresp;
	logic [3:0] fs, out, st;
	logic [3:0] ws, wsv;
	logic [31:0] wdr, em;
	int mismatches, samples_checked;
	logic [7:0] rja [4] = '{8'h04, 8'h04, 8'h08, 8'h00};
	logic [31:0] rjd [4] = '{32'h3b, 32'he101, 32'h0, 32'h3};
	logic [31:0] rje [4] = '{32'h3c, 32'h3c, 32'h1, 32'h0};

	swlt_top #(.TICK_CYC(TCK)) swlt_top_inst (.I_CLK_SYS(clk), .I_RST(rst),
		.I_ROLE_SENDER(role), .I_LINK_UP(link_up), .I_FRAME_VALID(fv),
		.I_FRAME_CH_STATE(fs), .I_AWVALID(awv), .I_AWADDR(aa), .O_AWREADY(awrdy),
		.I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(ws), .O_WREADY(wrdy),
		.O_BVALID(bvalid), .O_BRESP(bresp), .I_BREADY(bready), .I_ARVALID(arv),
		.I_ARADDR(ara), .O_ARREADY(arrdy), .O_RVALID(rvalid), .O_RDATA(rdata),
		.O_RRESP(rresp), .I_RREADY(rready), .O_CH_OUT(out), .O_LINK_INDICATOR(ind),
		.O_LINK_SEARCH(srch), .O_IRQ(irq));
	swlt_peer_model swlt_peer_model_inst (.i_clk(clk), .o_link_up(link_up),
		.o_frame_valid(fv), .o_frame_ch_state(fs));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// axi4-lite write, address and data released as each is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awv <= 1'b1;
		aa <= a;
		wv <= 1'b1;
		wd <= d;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awrdy) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	// axi4-lite read
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arrdy) arv <= 1'b0;
		end while (!rvalid);
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// expected mask after a strobed write: only byte lane 0 holds mask bits
	function automatic logic [31:0] exp_mask(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		return be[0] ? {28'h0, d[3:0]} : old;
	endfunction
	// read and compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdat, e);
	endtask
	// bounded wait for the channel outputs
	task automatic wait_out(input logic [3:0] e, input int n);
		for (int k = 0; k < n && out !== e; k++) @(negedge clk);
		chk(32'(out), 32'(e));
	endtask
	// reset with a role strap
	task automatic do_reset(input logic r);
		rst <= 1'b1;
		role <= r;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// verdict and end of run
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (10000) @(posedge clk);
		mismatches++;
		summarize();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		role = 1'b1;
		{awv, wv, bready, arv, rready} = 5'h0;
		aa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		ws = 4'hf;
		mismatches = 0;
		samples_checked = 0;
		void'($urandom(51698));
		// sending-end limits
		do_reset(1'b1);
		rchk(8'h04, 32'h14);
		wr(8'h04, 32'h13);
		rchk(8'h04, 32'h14);
		wr(8'h04, 32'he100);
		rchk(8'h04, 32'he100);
		// receiving-end defaults and refused values
		do_reset(1'b0);
		rchk(8'h04, 32'h3c);
		rchk(8'h08, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(rja[i], rjd[i]);
			rchk(rja[i], rje[i]);
		end
		rchk(8'h10, 32'h8);
		wr(8'h10, 32'h8);
		rchk(8'h10, 32'h0);
		// random data under random byte strobes into the mask
		em = 32'h0;
		for (int i = 0; i < 6; i++) begin
			wsv = 4'($urandom);
			wdr = $urandom;
			ws <= wsv;
			wr(8'h14, wdr);
			em = exp_mask(em, wdr, wsv);
			rchk(8'h14, em);
		end
		ws <= 4'hf;
		// unmapped place
		wr(8'h1c, 32'h5a);
		chk(32'(resp), 32'(swlt_pkg::RESP_SLVERR));
		rchk(8'h1c, 32'h0);
		chk(32'(resp), 32'(swlt_pkg::RESP_SLVERR));
		// follow mode with random frames
		for (int i = 0; i < 16; i++) begin
			st = 4'($urandom);
			swlt_peer_model_inst.send(st);
			@(negedge clk);
			chk(32'(out), 32'(st));
		end
		rchk(8'h18, 32'(st));
		chk(32'(ind), 32'h1);
		// toggle mode: invert once per close then open
		swlt_peer_model_inst.send(4'h0);
		wr(8'h00, 32'h1);
		swlt_peer_model_inst.send(4'h5);
		swlt_peer_model_inst.send(4'h0);
		wait_out(4'h5, 1);
		swlt_peer_model_inst.send(4'h1);
		swlt_peer_model_inst.send(4'h0);
		wait_out(4'h4, 1);
		// delayed close of two seconds
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h2);
		swlt_peer_model_inst.send(4'h4);
		swlt_peer_model_inst.send(4'h0);
		repeat (8) @(negedge clk);
		chk(32'(out), 32'h0);
		wait_out(4'h4, 30);
		// link loss past sixty seconds
		wr(8'h00, 32'h0);
		wr(8'h14, 32'h2);
		swlt_peer_model_inst.send(4'hf);
		swlt_peer_model_inst.link(1'b0);
		repeat (2) @(negedge clk);
		chk(32'(srch), 32'h1);
		repeat (585) @(negedge clk);
		chk(32'(out), 32'hf);
		wait_out(4'h0, 40);
		repeat (2) @(negedge clk);
		chk({ind, srch, irq}, 32'h3);
		rchk(8'h10, 32'h3);
		wr(8'h10, 32'h3);
		swlt_peer_model_inst.link(1'b1);
		swlt_peer_model_inst.send(4'h3);
		repeat (2) @(negedge clk);
		chk({out, ind, irq}, 32'he);
		rd(8'h0c);
		chk(rdat & 32'hffff0002, 32'h0);
		// recovery off holds outputs
		wr(8'h04, 32'h0);
		swlt_peer_model_inst.link(1'b0);
		repeat (800) @(negedge clk);
		chk(32'(out), 32'h3);
		swlt_peer_model_inst.link(1'b1);
		summarize();
	end
endmodule
